/* inc/dma_pkg.sv */
`default_nettype none
package dma_pkg;
  localparam int CHANNELS = 8;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 16;
  localparam int COUNT_WIDTH = 10;
  localparam int REQ_WIDTH = 7;
  // Control register fields
  localparam int CTL_ON = 15;
  localparam int CTL_SIZE = 14;
  localparam int CTL_DIR = 13;
  localparam int CTL_HALF = 12;
  localparam int CTL_NULL_PERIPHERAL_WRITE = 11;
  localparam int CTL_ADDRESSING_SELECT_LO = 4;
  localparam int CTL_MODE_LO = 0;
  localparam logic [15:0] CTL_MASK = 16'hf833;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  // Per-channel register slots: address = channel * 8 + slot
  localparam logic [2:0] SLOT_CONTROL = 3'h0;
  localparam logic [2:0] SLOT_REQUEST = 3'h1;
  localparam logic [2:0] SLOT_PRIMARY = 3'h2;
  localparam logic [2:0] SLOT_SECONDARY = 3'h3;
  localparam logic [2:0] SLOT_PERIPH = 3'h4;
  localparam logic [2:0] SLOT_COUNT = 3'h5;
  // Shared registers above the channel area
  localparam logic [7:0] ADDR_STATUS0 = 8'h40;
  localparam logic [7:0] ADDR_STATUS1 = 8'h41;
  localparam logic [7:0] ADDR_MASK = 8'h42;
  localparam logic [7:0] ADDR_HALF_STATUS = 8'h43;
  localparam logic [7:0] ADDR_CHANNEL_TOP = 8'h40;
  typedef enum logic [1:0] {
    AM_POST_INC, AM_NO_INC, AM_PERIPH_IND, AM_RESERVED
  } addressing_select_type;
  typedef enum logic [1:0] {
    OM_CONT, OM_ONESHOT, OM_CONT_PP, OM_ONESHOT_PP
  } opmode_type;
endpackage
`default_nettype wire

/* inc/xfer_if.sv */
`default_nettype none
interface xfer_if;
  import dma_pkg::*;
  logic [CHANNELS-1:0] fire;
  logic [CHANNELS-1:0] grant;
  logic [2:0] chan;
  logic busy;
  modport arb(input fire, output grant, output chan, output busy);
  modport core(output fire, input grant, input chan, input busy);
endinterface
`default_nettype wire

/* rtl/dma_arbiter.sv */
`default_nettype none
module dma_arbiter (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Channel requests and grant
  xfer_if.arb port
);
  import dma_pkg::*;
  logic [2:0] next_chan;
  logic found;
  // Fixed priority, channel 0 highest, like most small engines
  always_comb begin
    next_chan = 3'h0;
    found = 1'b0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (port.fire[i]) begin
        next_chan = 3'(i);
        found = 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port.chan <= 3'h0;
      port.busy <= 1'b0;
    end else begin
      port.chan <= next_chan;
      port.busy <= found;
    end
  end
  always_comb begin
    port.grant = '0;
    if (port.busy) begin
      port.grant[port.chan] = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* rtl/dma_channel_config.sv */
// Decided for this implementation: the register addresses and strobed register access.
`default_nettype none
module dma_channel_config #(
  parameter int COUNT_BITS = dma_pkg::COUNT_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [dma_pkg::ADDR_WIDTH-1:0] reg_addr,
  input wire logic [dma_pkg::DATA_WIDTH-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [dma_pkg::DATA_WIDTH-1:0] reg_rdata,
  // Peripheral request lines
  input wire logic [(1 << dma_pkg::REQ_WIDTH)-1:0] periph_req,
  // Transfer bus toward RAM and peripherals
  output logic xfer_valid,
  output logic [2:0] xfer_chan,
  output logic [dma_pkg::DATA_WIDTH-1:0] xfer_ram_addr,
  output logic [dma_pkg::DATA_WIDTH-1:0] xfer_periph_addr,
  output logic xfer_byte,
  output logic xfer_to_periph,
  output logic xfer_null_write,
  // Interrupt
  output logic irq
);
  import dma_pkg::*;

  logic [DATA_WIDTH-1:0] control [CHANNELS];
  logic [REQ_WIDTH-1:0] request [CHANNELS];
  logic [DATA_WIDTH-1:0] primary [CHANNELS];
  logic [DATA_WIDTH-1:0] secondary [CHANNELS];
  logic [DATA_WIDTH-1:0] periph [CHANNELS];
  logic [COUNT_BITS-1:0] count [CHANNELS];
  logic [COUNT_BITS-1:0] done_cnt [CHANNELS];
  logic [DATA_WIDTH-1:0] index [CHANNELS];
  logic [CHANNELS-1:0] use_secondary;
  logic [CHANNELS-1:0] pp_done_one;
  logic [CHANNELS-1:0] req_prev;
  logic [CHANNELS-1:0] pending;
  logic [CHANNELS-1:0] block_status;
  logic [CHANNELS-1:0] half_status;
  logic [CHANNELS-1:0] irq_mask;
  logic [CHANNELS-1:0] block_event;
  logic [CHANNELS-1:0] half_event;
  logic [CHANNELS-1:0] self_disable;
  logic [DATA_WIDTH-1:0] next_rdata;

  xfer_if bus ();
  dma_arbiter arb (
    .clk(clk),
    .sys_rst(sys_rst),
    .port(bus.arb)
  );

  wire logic [2:0] addr_chan = reg_addr[5:3];
  wire logic [2:0] addr_slot = reg_addr[2:0];
  wire logic in_channels = reg_addr < ADDR_CHANNEL_TOP;
  wire logic wr_status0 = reg_write && reg_addr == ADDR_STATUS0;
  wire logic wr_status1 = reg_write && reg_addr == ADDR_STATUS1;
  wire logic wr_mask = reg_write && reg_addr == ADDR_MASK;
  assign irq = |((block_status | half_status) & irq_mask);

  genvar c;
  for (c = 0; c < CHANNELS; c++) begin : g_chan
    wire logic sel = reg_write && in_channels && addr_chan == 3'(c);
    wire logic on = control[c][CTL_ON];
    wire addressing_select_type am = addressing_select_type'(control[c][CTL_ADDRESSING_SELECT_LO +: 2]);
    wire opmode_type om = opmode_type'(control[c][CTL_MODE_LO +: 2]);
    wire logic pingpong = om == OM_CONT_PP || om == OM_ONESHOT_PP;
    wire logic oneshot = om == OM_ONESHOT || om == OM_ONESHOT_PP;
    wire logic req_now = periph_req[request[c]];
    wire logic go = bus.grant[c];
    wire logic [COUNT_BITS-1:0] done_next = done_cnt[c] + 1'b1;
    // Count register holds transfers minus one
    wire logic last = go && done_cnt[c] == count[c];
    // Half point is unit ceil(n/2); no carry out of the count width
    wire logic mid = go && done_cnt[c] == (count[c] >> 1);
    wire logic final_blk = !pingpong || pp_done_one[c];
    // Reserved addressing mode behaves as no increment, a safe choice
    wire logic step = am == AM_POST_INC;
    wire logic [DATA_WIDTH-1:0] unit = control[c][CTL_SIZE] ?
      16'h0001 : 16'h0002;
    assign bus.fire[c] = pending[c] && on && !go;
    assign block_event[c] = last && !control[c][CTL_HALF];
    assign half_event[c] = mid && control[c][CTL_HALF];
    assign self_disable[c] = last && oneshot && final_blk;

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        control[c] <= CTL_RESET;
        request[c] <= '0;
        primary[c] <= '0;
        secondary[c] <= '0;
        periph[c] <= '0;
        count[c] <= '0;
      end else begin
        if (sel && addr_slot == SLOT_CONTROL) begin
          control[c] <= reg_wdata & CTL_MASK;
        end else if (self_disable[c]) begin
          control[c][CTL_ON] <= 1'b0;
        end
        if (sel && addr_slot == SLOT_REQUEST) begin
          request[c] <= reg_wdata[REQ_WIDTH-1:0];
        end
        if (sel && addr_slot == SLOT_PRIMARY) begin
          primary[c] <= reg_wdata;
        end
        if (sel && addr_slot == SLOT_SECONDARY) begin
          secondary[c] <= reg_wdata;
        end
        if (sel && addr_slot == SLOT_PERIPH) begin
          periph[c] <= reg_wdata;
        end
        if (sel && addr_slot == SLOT_COUNT) begin
          count[c] <= reg_wdata[COUNT_BITS-1:0];
        end
      end
    end

    // Transfer progress; a disabled channel restarts at primary buffer
    always_ff @(posedge clk) begin
      if (sys_rst || !on) begin
        done_cnt[c] <= '0;
        index[c] <= '0;
        use_secondary[c] <= 1'b0;
        pp_done_one[c] <= 1'b0;
        pending[c] <= 1'b0;
        req_prev[c] <= 1'b0;
      end else begin
        req_prev[c] <= req_now;
        // A request during the grant is kept, not dropped
        if (req_now && !req_prev[c]) begin
          pending[c] <= 1'b1;
        end else if (go) begin
          pending[c] <= 1'b0;
        end
        if (last) begin
          done_cnt[c] <= '0;
          index[c] <= '0;
          use_secondary[c] <= pingpong && !use_secondary[c];
          pp_done_one[c] <= pingpong && !pp_done_one[c];
        end else if (go) begin
          done_cnt[c] <= done_next;
          if (step) begin
            index[c] <= index[c] + unit;
          end
        end
      end
    end
  end

  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      block_status <= '0;
      half_status <= '0;
      irq_mask <= '0;
    end else begin
      block_status <= (block_status & ~({CHANNELS{wr_status0}} &
        reg_wdata[CHANNELS-1:0])) | block_event;
      half_status <= (half_status & ~({CHANNELS{wr_status1}} &
        reg_wdata[CHANNELS-1:0])) | half_event;
      if (wr_mask) begin
        irq_mask <= reg_wdata[CHANNELS-1:0];
      end
    end
  end

  // Transfer bus, registered one cycle after the grant
  wire logic [2:0] g = bus.chan;
  wire logic [DATA_WIDTH-1:0] base =
    use_secondary[g] ? secondary[g] : primary[g];
  wire addressing_select_type g_am = addressing_select_type'(control[g][CTL_ADDRESSING_SELECT_LO +: 2]);
  wire logic periph_ind = g_am == AM_PERIPH_IND;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xfer_valid <= 1'b0;
      xfer_chan <= 3'h0;
      xfer_ram_addr <= '0;
      xfer_periph_addr <= '0;
      xfer_byte <= 1'b0;
      xfer_to_periph <= 1'b0;
      xfer_null_write <= 1'b0;
    end else begin
      xfer_valid <= bus.busy;
      xfer_chan <= g;
      // Peripheral indirect uses the buffer base address alone, without the index
      xfer_ram_addr <= periph_ind ? base : base + index[g];
      xfer_periph_addr <= periph[g];
      xfer_byte <= control[g][CTL_SIZE];
      xfer_to_periph <= control[g][CTL_DIR];
      // Null write is meaningless with direction set, so it is gated
      xfer_null_write <= control[g][CTL_NULL_PERIPHERAL_WRITE] &&
        !control[g][CTL_DIR];
    end
  end

  // Read mux
  always_comb begin
    next_rdata = '0;
    if (in_channels) begin
      case (addr_slot)
        SLOT_CONTROL: next_rdata = control[addr_chan];
        SLOT_REQUEST: next_rdata = DATA_WIDTH'(request[addr_chan]);
        SLOT_PRIMARY: next_rdata = primary[addr_chan];
        SLOT_SECONDARY: next_rdata = secondary[addr_chan];
        SLOT_PERIPH: next_rdata = periph[addr_chan];
        SLOT_COUNT: next_rdata = DATA_WIDTH'(count[addr_chan]);
        default: next_rdata = '0;
      endcase
    end else begin
      case (reg_addr)
        ADDR_STATUS0: next_rdata = DATA_WIDTH'(block_status);
        ADDR_STATUS1: next_rdata = DATA_WIDTH'(half_status);
        ADDR_MASK: next_rdata = DATA_WIDTH'(irq_mask);
        ADDR_HALF_STATUS: next_rdata = DATA_WIDTH'(use_secondary);
        default: next_rdata = '0;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_read ? next_rdata : '0;
    end
  end
endmodule
`default_nettype wire

/* sim/dma_channel_config_sva.sv */
`default_nettype none
module dma_channel_config_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [dma_pkg::ADDR_WIDTH-1:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [dma_pkg::DATA_WIDTH-1:0] reg_rdata,
  // Transfer and interrupt
  input wire logic xfer_valid,
  input wire logic [2:0] xfer_chan,
  input wire logic xfer_to_periph,
  input wire logic xfer_null_write,
  input wire logic irq
);
  import dma_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire in_chan = reg_addr < ADDR_CHANNEL_TOP;
  wire [2:0] slot = reg_addr[2:0];
  wire hole = in_chan ? slot[2:1] == 2'b11 : reg_addr > ADDR_HALF_STATUS;
  rdata_idle_a: assert property (
    !$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data outside answer cycle");
  ctl_zero_a: assert property (
    reg_read && in_chan && slot == SLOT_CONTROL |=>
    (reg_rdata & ~CTL_MASK) == 16'h0000)
    else $error("unimplemented control bit set");
  req_width_a: assert property (
    reg_read && in_chan && slot == SLOT_REQUEST |=> reg_rdata[15:7] == 0)
    else $error("request select too wide");
  cnt_width_a: assert property (
    reg_read && in_chan && slot == SLOT_COUNT |=> reg_rdata[15:10] == 0)
    else $error("transfer count too wide");
  hole_zero_a: assert property (
    reg_read && hole |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  null_dir_a: assert property (
    xfer_valid && xfer_to_periph |-> !xfer_null_write)
    else $error("null write toward peripheral");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(reg_write))
    else $error("interrupt dropped without a write");
  start_quiet_a: assert property (
    $fell(sys_rst) |-> !xfer_valid && !irq && reg_rdata == 16'h0000)
    else $error("outputs not quiet after reset");
  xfer_gap_a: assert property (
    xfer_valid |=> !xfer_valid || xfer_chan != $past(xfer_chan))
    else $error("channel transferred twice in a row");
endmodule
bind dma_channel_config dma_channel_config_sva dma_channel_config_sva_i (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .xfer_valid(xfer_valid), .xfer_chan(xfer_chan),
  .xfer_to_periph(xfer_to_periph), .xfer_null_write(xfer_null_write),
  .irq(irq));
`default_nettype wire

/* sim/periph_model.sv */
`default_nettype none
module periph_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Command from the bench
  input wire logic go,
  input wire logic [6:0] sel,
  // Request lines
  output logic [127:0] periph_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // Only one line high at a time, so each rise is one request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      periph_req <= '0;
    end else begin
      periph_req <= go ? (128'h1 << sel) : '0;
    end
  end
endmodule
`default_nettype wire

/* sim/tb_dma_channel_config.sv */
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
  n_errors++; $display("ERROR %0t %h %h", $time, a, b); end end
module tb_dma_channel_config;
  timeunit 1ns;
  timeprecision 1ns;
  import dma_pkg::*;
  logic clk = 0, sys_rst = 1, reg_write = 0, reg_read = 0, go = 0;
  logic [7:0] reg_addr = 0;
  logic [6:0] sel = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, rd_v, pad, ea, cv;
  logic [15:0] xfer_ram_addr, xfer_periph_addr, st [2];
  logic [127:0] periph_req;
  logic [2:0] xfer_chan;
  logic xfer_valid, xfer_byte, xfer_to_periph, xfer_null_write, irq;
  int n_errors = 0, num_checks = 0;
  integer seed = 32'he7b2_2d76;
  always #20 clk = ~clk;
  dma_channel_config dma_channel_config_i (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .periph_req(periph_req),
    .xfer_valid(xfer_valid), .xfer_chan(xfer_chan),
    .xfer_ram_addr(xfer_ram_addr), .xfer_periph_addr(xfer_periph_addr),
    .xfer_byte(xfer_byte), .xfer_to_periph(xfer_to_periph),
    .xfer_null_write(xfer_null_write), .irq(irq));
  periph_model periph_model_i (.clk(clk), .sys_rst(sys_rst), .go(go),
    .sel(sel), .periph_req(periph_req));
  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] keep(input int s);
    case (s)
      0: keep = CTL_MASK;
      1: keep = 16'h007f;
      5: keep = 16'h03ff;
      6, 7: keep = 16'h0000;
      default: keep = 16'hffff;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1;
    @(posedge clk);
    reg_write <= 0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1;
    @(posedge clk);
    reg_read <= 0;
    #1 rd_v = reg_rdata;
  endtask
  task automatic unit(input logic [15:0] ctl, input int c);
    int t;
    t = 0;
    // Random idle gap so the far side is sometimes slow
    repeat ($random(seed) & 3) @(posedge clk);
    @(posedge clk);
    go <= 1;
    @(posedge clk);
    go <= 0;
    do begin
      @(posedge clk);
      #1 t++;
    end while (xfer_valid !== 1'b1 && t < 12);
    if (t >= 12) begin
      n_errors++;
      summarize();
    end
    `CHK(xfer_chan, c[2:0])
    `CHK(xfer_ram_addr, ea)
    `CHK(xfer_periph_addr, pad)
    `CHK(xfer_byte, ctl[14])
    `CHK(xfer_to_periph, ctl[13])
    `CHK(xfer_null_write, ctl[11])
  endtask
  task automatic blk(input int c, input logic [15:0] ctl, input int n);
    int nb;
    logic [7:0] a;
    logic [6:0] s;
    a = 8'(c * 8);
    s = 7'($random(seed));
    sel <= s;
    pad = 16'($random(seed));
    st[0] = 16'($random(seed));
    st[1] = 16'($random(seed));
    wr(a + 1, {9'h000, s});
    wr(a + 2, st[0]);
    wr(a + 3, st[1]);
    wr(a + 4, pad);
    wr(a + 5, 16'(n));
    wr(ADDR_MASK, 16'(1 << c));
    wr(a, ctl);
    nb = ctl[1:0] == 2'b01 ? 1 : 2;
    for (int b = 0; b < nb; b++) begin
      for (int k = 0; k <= n; k++) begin
        ea = st[ctl[1] & b[0]];
        if (ctl[5:4] == 2'b00) begin
          ea += 16'(k * (ctl[14] ? 1 : 2));
        end
        unit(ctl, c);
      end
      rd(ctl[12] ? ADDR_STATUS1 : ADDR_STATUS0);
      `CHK(rd_v[c], 1'b1)
      rd(ADDR_HALF_STATUS);
      `CHK(rd_v[c], ctl[1] & ~b[0])
      `CHK(irq, 1'b1)
      wr(ADDR_MASK, 16'h0000);
      `CHK(irq, 1'b0)
      wr(ADDR_MASK, 16'(1 << c));
      wr(ADDR_STATUS0, 16'h00ff);
      wr(ADDR_STATUS1, 16'h00ff);
      `CHK(irq, 1'b0)
    end
    rd(a);
    `CHK(rd_v, ctl[0] ? ctl & 16'h7fff : ctl)
    wr(a, 16'h0000);
    @(posedge clk);
    go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (6) begin
      @(posedge clk);
      #1 `CHK(xfer_valid, 1'b0)
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    for (int a = 0; a < 68; a++) begin
      rd(8'(a));
      `CHK(rd_v, 16'h0000)
      if (a < 64) begin
        cv = 16'($random(seed)) & 16'h7fff;
        wr(8'(a), cv);
        rd(8'(a));
        `CHK(rd_v, cv & keep(a % 8))
      end
    end
    rd(8'hff);
    `CHK(rd_v, 16'h0000)
    for (int m = 0; m < 8; m++) begin
      cv = 16'($random(seed)) & 16'h7830 | 16'h8000 | 16'(m % 4);
      if (cv[11]) cv[13] = 1'b0;
      blk(m, cv, 1 + m % 3);
    end
    summarize();
  end
endmodule
`default_nettype wire
